// *** common/vsi_map.svh ***
`ifndef VSI_MAP_SVH
`define VSI_MAP_SVH
// Overview of operation
// - Five-bit format code names the detected video standard from a fixed table.
// - Lock flag goes high when the flywheel is fully synchronised.
// - Interlace flag is zero for progressive, one for interlaced standards.
// - Code, lock flag and interlace flag are zero after reset.
// - Code and interlace flag forced zero when path select or lock is low.
// - Lock flag holds its last value if the pixel clock stops.
// - Codes 00h to 09h are 720p rates 60,30,50,25,24, each then EM.
// - Codes 0Ah-13h are 1080 rasters; 14h 1080i50, 15h 1035i60.
// - 525-line rasters give 16h,17h,19h,1Bh; 625-line give 18h or 1Ah.
// - 59.94 Hz and 60 Hz give the same code.
// - Lock cannot rise before one complete frame has been timed.
// - Timing source select high locks to embedded timing words, else to H, V, F.
`define VSI_CODE_UNK_HD 5'h1D
`define VSI_CODE_UNK_SD 5'h1E
`define VSI_SD_TOTAL_MAX 12'h6C0
`endif

// *** common/vsi_pkg.sv ***
package vsi_pkg;
    typedef struct packed {
        logic [4:0] code;
        logic       ilace;
    } vsi_match_type;
    typedef struct packed {
        logic [4:0] code_r;
        logic       ilace_r;
        logic       lock_r;
    } vsi_state_type;
endpackage : vsi_pkg

// *** core/vsi_classify.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "vsi_map.svh"
module vsi_classify (
    input  wire logic [11:0]      total_samples_i,
    input  wire logic [11:0]      active_samples_i,
    input  wire logic [10:0]      total_lines_i,
    input  wire logic [10:0]      active_lines_i,
    output vsi_pkg::vsi_match_type match_o
);
    function automatic vsi_pkg::vsi_match_type pick(input logic [4:0] c, input logic i);
        vsi_pkg::vsi_match_type m;
        m.code  = c;
        m.ilace = i;
        return m;
    endfunction : pick
    // frame rate not measured, so 59.94 and 60 alias
    always_comb begin
        match_o = pick(`VSI_CODE_UNK_HD, 1'b0);
        if (total_lines_i == 11'd750) begin
            case ({total_samples_i, active_samples_i})
                {12'd1650, 12'd1280}: match_o = pick(5'h00, 1'b0);
                {12'd1650, 12'd1440}: match_o = pick(5'h01, 1'b0);
                {12'd3300, 12'd1280}: match_o = pick(5'h02, 1'b0);
                {12'd3300, 12'd2880}: match_o = pick(5'h03, 1'b0);
                {12'd1980, 12'd1280}: match_o = pick(5'h04, 1'b0);
                {12'd1980, 12'd1728}: match_o = pick(5'h05, 1'b0);
                {12'd3960, 12'd1280}: match_o = pick(5'h06, 1'b0);
                {12'd3960, 12'd3456}: match_o = pick(5'h07, 1'b0);
                {12'd4095, 12'd1280}: match_o = pick(5'h08, 1'b0);
                {12'd4095, 12'd3600}: match_o = pick(5'h09, 1'b0);
                default:              match_o = pick(`VSI_CODE_UNK_HD, 1'b0);
            endcase
        end else if (total_lines_i == 11'd1125) begin
            // 1080/1035 codes; field-sized active count marks interlace/PsF
            logic il;
            il = (active_lines_i < 11'd600);
            case ({total_samples_i, active_samples_i})
                {12'd2200, 12'd1920}:
                    match_o = (active_lines_i == 11'd517) ? pick(5'h15, 1'b1)
                            : (il ? pick(5'h0A, 1'b1) : pick(5'h0B, 1'b0));
                {12'd2640, 12'd1920}: match_o = il ? pick(5'h0C, 1'b1) : pick(5'h0D, 1'b0);
                {12'd2640, 12'd2304}: match_o = il ? pick(5'h0F, 1'b1) : pick(5'h0E, 1'b0);
                {12'd2750, 12'd1920}: match_o = il ? pick(5'h11, 1'b1) : pick(5'h10, 1'b0);
                {12'd2750, 12'd2400}: match_o = il ? pick(5'h13, 1'b1) : pick(5'h12, 1'b0);
                default:              match_o = pick(`VSI_CODE_UNK_HD, 1'b0);
            endcase
        end else if (total_lines_i == 11'd1250 && total_samples_i == 12'd2376) begin
            match_o = pick(5'h14, 1'b1);
        end else if (total_lines_i == 11'd525 && total_samples_i == 12'd1716) begin
            if (active_samples_i == 12'd1440)
                match_o = (active_lines_i >= 11'd253) ? pick(5'h17, 1'b1) : pick(5'h16, 1'b1);
            else
                match_o = (active_lines_i >= 11'd253) ? pick(5'h1B, 1'b1) : pick(5'h19, 1'b1);
        end else if (total_lines_i == 11'd625 && total_samples_i == 12'd1728) begin
            match_o = (active_samples_i == 12'd1440) ? pick(5'h18, 1'b1) : pick(5'h1A, 1'b1);
        end else if (total_samples_i <= `VSI_SD_TOTAL_MAX) begin
            // unknown SD, reserved codes never produced
            match_o = pick(`VSI_CODE_UNK_SD, 1'b0);
        end
    end
endmodule : vsi_classify
`default_nettype wire

// *** core/vsi_indicator.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "vsi_map.svh"
module vsi_indicator (
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        clk_en_i,
    input  wire logic        processing_path_select_i,
    input  wire logic        timing_source_select_i,
    input  wire logic        trs_lock_i,
    input  wire logic        hvf_lock_i,
    input  wire logic        frame_done_i,
    input  wire logic        lock_out_i,
    input  wire logic [11:0] total_samples_i,
    input  wire logic [11:0] active_samples_i,
    input  wire logic [10:0] total_lines_i,
    input  wire logic [10:0] active_lines_i,
    output logic      [4:0]  video_format_code_o,
    output logic             format_lock_flag_o,
    output logic             interlace_flag_o
);
    vsi_pkg::vsi_state_type st_r;
    vsi_pkg::vsi_state_type st_nxt;
    vsi_pkg::vsi_match_type match;
    logic                   frame_seen_r;
    logic                   sync_ok;

    vsi_classify u_classify (
        .total_samples_i  (total_samples_i),
        .active_samples_i (active_samples_i),
        .total_lines_i    (total_lines_i),
        .active_lines_i   (active_lines_i),
        .match_o          (match)
    );

    always_comb begin
        st_nxt  = st_r;
        sync_ok = timing_source_select_i ? trs_lock_i : hvf_lock_i;
        st_nxt.lock_r = sync_ok && frame_seen_r;
        if (!processing_path_select_i || !lock_out_i) begin
            st_nxt.code_r  = 5'h00;
            st_nxt.ilace_r = 1'b0;
        end else begin
            st_nxt.code_r  = match.code;
            st_nxt.ilace_r = match.ilace;
        end
    end

    // sync reset; stopped clock freezes lock
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_r         <= '0;
            frame_seen_r <= 1'b0;
        end else if (clk_en_i) begin
            st_r         <= st_nxt;
            frame_seen_r <= sync_ok && (frame_seen_r || frame_done_i);
        end
    end

    assign video_format_code_o = st_r.code_r;
    assign format_lock_flag_o  = st_r.lock_r;
    assign interlace_flag_o    = st_r.ilace_r;

    a_force_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        clk_en_i && !processing_path_select_i |=> video_format_code_o == 5'h00
        && !interlace_flag_o) else $error("code not forced to zero");
    a_unlock_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        clk_en_i && !lock_out_i |=> video_format_code_o == 5'h00
        && !interlace_flag_o) else $error("code not forced while unlocked");
    a_lock_frame: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(format_lock_flag_o) |-> frame_seen_r) else $error("lock before frame");
    a_no_reserved: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        video_format_code_o != 5'h1C && video_format_code_o != 5'h1F)
        else $error("reserved code reported");
    a_lock_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !clk_en_i |=> $stable(format_lock_flag_o)) else $error("lock moved while frozen");
    a_reset_clear: assert property (@(posedge sys_clk_i)
        !rstn_i |=> video_format_code_o == 5'h00 && !format_lock_flag_o
        && !interlace_flag_o) else $error("outputs not cleared by reset");
    sequence s_sync_lost;
        clk_en_i && !sync_ok;
    endsequence
    a_lock_drop: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        s_sync_lost |=> !format_lock_flag_o) else $error("lock held without sync");
endmodule : vsi_indicator
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        clk, rstn, en, path, tsel, trs, hvf, fd, lko;
    logic [11:0] ts, as;
    logic [10:0] tl, al;
    logic [4:0]  code;
    logic        lock, il;
    int          errors, tests_run, cyc;
    vsi_indicator dut (.sys_clk_i(clk), .rstn_i(rstn), .clk_en_i(en),
        .processing_path_select_i(path), .timing_source_select_i(tsel), .trs_lock_i(trs),
        .hvf_lock_i(hvf), .frame_done_i(fd), .lock_out_i(lko), .total_samples_i(ts),
        .active_samples_i(as), .total_lines_i(tl), .active_lines_i(al),
        .video_format_code_o(code), .format_lock_flag_o(lock), .interlace_flag_o(il));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic check(input string nm, input logic [4:0] seen, input logic [4:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // Hang guard, run needs well under 300 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic pulse_frame;
        fd = 1'b1;
        tick(1);
        fd = 1'b0;
        tick(2);
    endtask : pulse_frame
    task automatic t_lock;
        path = 1'b1;
        lko = 1'b1;
        tsel = 1'b1;
        trs = 1'b1;
        tick(3);
        check("lock_early", 5'(lock), 5'h00);
        pulse_frame();
        check("lock_trs", 5'(lock), 5'h01);
        en = 1'b0;
        trs = 1'b0;
        tick(3);
        check("lock_hold", 5'(lock), 5'h01);
        en = 1'b1;
        tsel = 1'b0;
        hvf = 1'b1;
        pulse_frame();
        check("lock_hvf", 5'(lock), 5'h01);
        tsel = 1'b1;
        tick(2);
        check("lock_sel", 5'(lock), 5'h00);
        tsel = 1'b0;
        pulse_frame();
    endtask : t_lock
    task automatic fmt(input logic [11:0] t, input logic [11:0] a, input logic [10:0] l,
                       input logic [10:0] v, input logic [4:0] c, input logic i);
        ts = t;
        as = a;
        tl = l;
        al = v;
        tick(2);
        check("code", code, c);
        check("ilace", 5'(il), 5'(i));
    endtask : fmt
    task automatic t_codes;
        fmt(12'h672, 12'h500, 11'h2EE, 11'h2D0, 5'h00, 1'b0);
        fmt(12'h7BC, 12'h500, 11'h2EE, 11'h2D0, 5'h04, 1'b0);
        fmt(12'h898, 12'h780, 11'h465, 11'h21C, 5'h0A, 1'b1);
        fmt(12'h898, 12'h780, 11'h465, 11'h438, 5'h0B, 1'b0);
        fmt(12'h6B4, 12'h5A0, 11'h20D, 11'h0F3, 5'h16, 1'b1);
        fmt(12'h6C0, 12'h5A0, 11'h271, 11'h120, 5'h18, 1'b1);
        fmt(12'h6C0, 12'h500, 11'h271, 11'h120, 5'h1A, 1'b1);
        fmt(12'h6B4, 12'h500, 11'h20D, 11'h0FD, 5'h1B, 1'b1);
        fmt(12'hFFF, 12'hE10, 11'h2EE, 11'h2D0, 5'h09, 1'b0);
        fmt(12'hA50, 12'h900, 11'h465, 11'h21C, 5'h0F, 1'b1);
        fmt(12'h898, 12'h780, 11'h465, 11'h205, 5'h15, 1'b1);
        fmt(12'h948, 12'h780, 11'h4E2, 11'h21C, 5'h14, 1'b1);
        ts = 12'h3E8;
        tick(2);
        check("unk_sd", code, 5'h1E);
        ts = 12'h9C4;
        tick(2);
        check("unk_hd", code, 5'h1D);
        path = 1'b0;
        tick(2);
        check("bypass", code, 5'h00);
        path = 1'b1;
        lko = 1'b0;
        tick(2);
        check("unlocked", code, 5'h00);
    endtask : t_codes
    initial begin
        {rstn, en, path, tsel, trs, hvf, fd, lko, ts, as, tl, al} = '0;
        errors = 0;
        tests_run = 0;
        cyc = 0;
        tick(16);
        rstn = 1'b1;
        en = 1'b1;
        check("rst_code", code, 5'h00);
        check("rst_lock", 5'(lock), 5'h00);
        check("rst_ilace", 5'(il), 5'h00);
        t_lock();
        t_codes();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
